// ---- tac_pkg.sv ----
// Shared constants and types for the trigger arm control block.
// Assumes one 250 MHz clock, mclk, and a synchronous active-low reset.
// How it works
// - With the timer as trigger source, the timer starts only after an arm event.
// - Non-timer trigger source with arm source not always-armed raises error -221.
// - Software arm command arms when arm source is bus or hold.
// - Reset sets the arm source to always-armed.
// - External source takes its arm event from the terminal trigger input.
// - Always-armed source keeps the arm condition permanently true.
// - Backplane source arms from any one of eight selectable lines, 0 to 7.
// - Plug-on source takes its arm event from the plug-on trigger bus.
// - In timer mode an arm event is needed only before the first scan.
// - After each timer scan the timer keeps running and waits for trigger.
// - Abort lets the running scan finish, then returns to idle.
// - With always-armed source and the timer as trigger source, initiate alone starts scanning.
// - Arm source changes are refused while initiated.
// - Arm source query returns the source and the backplane line number.
// - Update window query returns the 16-bit update slot count.
// - Initiate with pending updates applies them as part of initiation.
// - Update window settable from 1 to 512, defaults to 20.
package tac_pkg;

    // Arm source selection codes.
    typedef enum logic [2:0] {
        ARM_BUS  = 3'h0,
        ARM_TRM  = 3'h1,
        ARM_HOLD = 3'h2,
        ARM_ALW  = 3'h3,
        ARM_PLG  = 3'h4,
        ARM_TTL  = 3'h5
    } tac_arm_src_e;

    // Trigger source selection codes.
    typedef enum logic [1:0] {
        TRIG_TIMER = 2'h0,
        TRIG_BUS   = 2'h1,
        TRIG_TRM   = 2'h2,
        TRIG_ALW   = 2'h3
    } tac_trig_src_e;

    // Trigger system states.
    typedef enum logic [1:0] {
        ST_IDLE      = 2'b00,
        ST_WAIT_ARM  = 2'b01,
        ST_WAIT_TRIG = 2'b10,
        ST_SCAN      = 2'b11
    } tac_state_e;

    localparam int            TAC_TTL_LINES      = 8;
    localparam int            TAC_SYNC_BITS      = TAC_TTL_LINES + 2;
    localparam int            TAC_TRM_BIT        = TAC_TTL_LINES;
    localparam int            TAC_PLG_BIT        = TAC_TTL_LINES + 1;
    localparam logic [2:0]    TAC_LINE_RESET     = 3'h0;
    localparam logic [15:0]   TAC_ERR_CONFLICT   = 16'hff23;
    localparam logic [15:0]   TAC_WINDOW_DEFAULT = 16'h0014;
    localparam logic [15:0]   TAC_WINDOW_MIN     = 16'h0001;
    localparam logic [15:0]   TAC_WINDOW_MAX     = 16'h0200;
    localparam tac_arm_src_e  TAC_ARM_RESET      = ARM_ALW;
    localparam tac_trig_src_e TAC_TRIG_RESET     = TRIG_TIMER;

endpackage

// ---- tac_arm_select.sv ----
// Arm source synchroniser and selector.
// Assumes the pins arrive asynchronously to mclk and settings come from mclk logic.
`timescale 1ns/100ps
module tac_arm_select (
    // Clock and reset.
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    // Asynchronous arm pins.
    input  wire logic                        terminalTriggerInput,
    input  wire logic                        plugOnTriggerBus,
    input  wire logic [tac_pkg::TAC_TTL_LINES-1:0] ttlTrigLines,
    // Selection and software arm.
    input  wire tac_pkg::tac_arm_src_e       armSourceSelect,
    input  wire logic [2:0]                  armLineSelect,
    input  wire logic                        softwareArmCommand,
    // Selected arm event.
    output logic                             armEvent
);
    import tac_pkg::*;

    logic [TAC_SYNC_BITS-1:0] syncFirst_reg;
    logic [TAC_SYNC_BITS-1:0] syncSecond_reg;
    logic [TAC_SYNC_BITS-1:0] syncLast_reg;
    logic [TAC_SYNC_BITS-1:0] riseEdge;
    logic [TAC_SYNC_BITS-1:0] pinVec;

    ////////////////////////////////////////////////////////////////////////
    // Gather the pins into one vector and detect edges per bit.
    genvar gi;
    generate
        for (gi = 0; gi < TAC_SYNC_BITS; gi++) begin : gSync
            if (gi < TAC_TTL_LINES) begin : gTtl
                assign pinVec[gi] = ttlTrigLines[gi];
            end else if (gi == TAC_TRM_BIT) begin : gTrm
                assign pinVec[gi] = terminalTriggerInput;
            end else begin : gPlg
                assign pinVec[gi] = plugOnTriggerBus;
            end
            // A rising edge on the synchronised level is one arm event.
            assign riseEdge[gi] = syncSecond_reg[gi] & ~syncLast_reg[gi];
        end
    endgenerate

    // Two-flop synchronisers for all pins, plus a delay stage for edges.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            syncFirst_reg  <= '0;
            syncSecond_reg <= '0;
            syncLast_reg   <= '0;
        end else begin
            syncFirst_reg  <= pinVec;
            syncSecond_reg <= syncFirst_reg;
            syncLast_reg   <= syncSecond_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Only the selected source may produce an arm event.
    always_comb begin
        case (armSourceSelect)
            ARM_BUS, ARM_HOLD: armEvent = softwareArmCommand;
            ARM_TRM:           armEvent = riseEdge[TAC_TRM_BIT];
            ARM_ALW:           armEvent = 1'b1;
            ARM_PLG:           armEvent = riseEdge[TAC_PLG_BIT];
            ARM_TTL:           armEvent = riseEdge[armLineSelect];
            default:           armEvent = 1'b0;
        endcase
    end

endmodule

// ---- tac_trigger_arm.sv ----
// Trigger arm control: settings, trigger state machine, queries and errors.
// Assumes command strobes are one-cycle pulses from mclk logic and the
// scan engine reports scan completion with a one-cycle pulse.
`timescale 1ns/100ps
module tac_trigger_arm (
    // Clock and reset.
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    // Asynchronous arm pins.
    input  wire logic                        terminalTriggerInput,
    input  wire logic                        plugOnTriggerBus,
    input  wire logic [tac_pkg::TAC_TTL_LINES-1:0] ttlTrigLines,
    // Setting commands.
    input  wire logic                        setArmSource,
    input  wire tac_pkg::tac_arm_src_e       armSourceValue,
    input  wire logic [2:0]                  armLineValue,
    input  wire logic                        setTriggerSource,
    input  wire tac_pkg::tac_trig_src_e      triggerSourceValue,
    input  wire logic                        setUpdateWindow,
    input  wire logic [15:0]                 updateWindowValue,
    // Control commands.
    input  wire logic                        softwareArmCommand,
    input  wire logic                        initiateCmd,
    input  wire logic                        abortCmd,
    input  wire logic                        updatesPending,
    // Scan engine.
    input  wire logic                        timerExpired,
    input  wire logic                        triggerEvent,
    input  wire logic                        scanDone,
    output logic                             timerRun,
    output logic                             scanStart,
    output logic                             initiated,
    output logic                             applyUpdates,
    // Queries.
    input  wire logic                        armSourceQuery,
    output logic                             armQueryValid,
    output tac_pkg::tac_arm_src_e            armQuerySource,
    output logic [2:0]                       armQueryLine,
    input  wire logic                        updateSlotCountQuery,
    output logic                             windowQueryValid,
    output logic [15:0]                      windowQueryData,
    // Errors and refusals.
    output logic                             errValid,
    output logic [15:0]                      errCode,
    output logic                             cmdRefused
);
    import tac_pkg::*;

    tac_state_e    state_reg;
    tac_state_e    state_next;
    tac_arm_src_e  armSrc_reg;
    logic [2:0]    armLine_reg;
    tac_trig_src_e trigSrc_reg;
    logic [15:0]   window_reg;
    logic          abortPending_reg;
    logic          timerRun_reg;
    logic          scanStart_reg;
    logic          applyUpdates_reg;
    logic          armQueryValid_reg;
    tac_arm_src_e  armQuerySource_reg;
    logic [2:0]    armQueryLine_reg;
    logic          windowQueryValid_reg;
    logic [15:0]   windowQueryData_reg;
    logic          errValid_reg;
    logic          cmdRefused_reg;
    logic          armEvent;
    logic          isIdle;
    logic          trigHit;
    logic          windowOk;
    logic          conflictNow;
    logic          conflictSet;

    ////////////////////////////////////////////////////////////////////////
    // Arm source selection and pin synchronisation.
    tac_arm_select uArmSelect (
        .mclk                 (mclk),
        .nrst                 (nrst),
        .terminalTriggerInput (terminalTriggerInput),
        .plugOnTriggerBus     (plugOnTriggerBus),
        .ttlTrigLines         (ttlTrigLines),
        .armSourceSelect      (armSrc_reg),
        .armLineSelect        (armLine_reg),
        .softwareArmCommand   (softwareArmCommand),
        .armEvent             (armEvent)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers.
    assign isIdle      = (state_reg == ST_IDLE);
    assign trigHit     = (trigSrc_reg == TRIG_TIMER) ? timerExpired : triggerEvent;
    assign windowOk    = (updateWindowValue >= TAC_WINDOW_MIN) && (updateWindowValue <= TAC_WINDOW_MAX);
    assign conflictNow = (trigSrc_reg != TRIG_TIMER) && (armSrc_reg != ARM_ALW);

    // Conflict seen with the values that an accepted setting would leave.
    always_comb begin
        conflictSet = 1'b0;
        if (isIdle && setArmSource) begin
            conflictSet = (trigSrc_reg != TRIG_TIMER) && (armSourceValue != ARM_ALW);
        end else if (isIdle && setTriggerSource) begin
            conflictSet = (triggerSourceValue != TRIG_TIMER) && (armSrc_reg != ARM_ALW);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings, changeable only while idle.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            armSrc_reg  <= TAC_ARM_RESET;
            armLine_reg <= TAC_LINE_RESET;
            trigSrc_reg <= TAC_TRIG_RESET;
            window_reg  <= TAC_WINDOW_DEFAULT;
        end else begin
            if (setArmSource && isIdle) begin
                armSrc_reg  <= armSourceValue;
                armLine_reg <= armLineValue;
            end
            if (setTriggerSource && isIdle) begin
                trigSrc_reg <= triggerSourceValue;
            end
            if (setUpdateWindow && isIdle && windowOk) begin
                window_reg <= updateWindowValue;
            end
        end
    end

    // Refusal pulse for settings sent while initiated or out of range.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cmdRefused_reg <= 1'b0;
        end else begin
            cmdRefused_reg <= (!isIdle && (setArmSource || setTriggerSource || setUpdateWindow))
                           || (setUpdateWindow && !windowOk);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger state machine.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (initiateCmd) begin
                    state_next = (trigSrc_reg == TRIG_TIMER) ? ST_WAIT_ARM : ST_WAIT_TRIG;
                end
            end
            ST_WAIT_ARM: begin
                if (abortCmd) begin
                    state_next = ST_IDLE;
                end else if (armEvent) begin
                    state_next = ST_WAIT_TRIG;
                end
            end
            ST_WAIT_TRIG: begin
                if (abortCmd) begin
                    state_next = ST_IDLE;
                end else if (trigHit) begin
                    state_next = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (scanDone) begin
                    // Later scans return to waiting for trigger, never to arming.
                    state_next = (abortPending_reg || abortCmd) ? ST_IDLE : ST_WAIT_TRIG;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Abort arriving mid-scan is held until the scan completes.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            abortPending_reg <= 1'b0;
        end else if (state_reg == ST_SCAN && abortCmd && !scanDone) begin
            abortPending_reg <= 1'b1;
        end else if (state_next == ST_IDLE) begin
            abortPending_reg <= 1'b0;
        end
    end

    // Timer runs from the arm event until the system returns to idle.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            timerRun_reg <= 1'b0;
        end else begin
            timerRun_reg <= (trigSrc_reg == TRIG_TIMER)
                         && (state_next == ST_WAIT_TRIG || state_next == ST_SCAN);
        end
    end

    // Scan start pulse, and update apply pulse at initiation.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            scanStart_reg    <= 1'b0;
            applyUpdates_reg <= 1'b0;
        end else begin
            scanStart_reg    <= (state_reg == ST_WAIT_TRIG) && !abortCmd && trigHit;
            applyUpdates_reg <= isIdle && initiateCmd && updatesPending;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings conflict reported on initiate and on a conflicting setting.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            errValid_reg <= 1'b0;
        end else begin
            errValid_reg <= (isIdle && initiateCmd && conflictNow) || conflictSet;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Query answers, one cycle after the request.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            armQueryValid_reg    <= 1'b0;
            armQuerySource_reg   <= TAC_ARM_RESET;
            armQueryLine_reg     <= TAC_LINE_RESET;
            windowQueryValid_reg <= 1'b0;
            windowQueryData_reg  <= TAC_WINDOW_DEFAULT;
        end else begin
            armQueryValid_reg    <= armSourceQuery;
            windowQueryValid_reg <= updateSlotCountQuery;
            if (armSourceQuery) begin
                armQuerySource_reg <= armSrc_reg;
                armQueryLine_reg   <= armLine_reg;
            end
            if (updateSlotCountQuery) begin
                windowQueryData_reg <= window_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign timerRun         = timerRun_reg;
    assign scanStart        = scanStart_reg;
    assign initiated        = !isIdle;
    assign applyUpdates     = applyUpdates_reg;
    assign armQueryValid    = armQueryValid_reg;
    assign armQuerySource   = armQuerySource_reg;
    assign armQueryLine     = armQueryLine_reg;
    assign windowQueryValid = windowQueryValid_reg;
    assign windowQueryData  = windowQueryData_reg;
    assign errValid         = errValid_reg;
    assign errCode          = TAC_ERR_CONFLICT;
    assign cmdRefused       = cmdRefused_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence seqArmTaken;
        state_reg == ST_WAIT_ARM && armEvent && !abortCmd;
    endsequence

    sequence seqScanEnds;
        state_reg == ST_SCAN && scanDone && !abortPending_reg && !abortCmd;
    endsequence

    AST_NO_TIMER_UNARMED: assert property (@(posedge mclk) disable iff (!nrst)
        state_reg == ST_WAIT_ARM |-> !timerRun)
        else $error("Timer runs before the arm event.");

    AST_ARM_STARTS_TIMER: assert property (@(posedge mclk) disable iff (!nrst)
        seqArmTaken |=> timerRun && state_reg == ST_WAIT_TRIG)
        else $error("Arm event did not start the timer.");

    AST_CONFLICT: assert property (@(posedge mclk) disable iff (!nrst)
        isIdle && initiateCmd && conflictNow |=> errValid && errCode == 16'hff23)
        else $error("Settings conflict not reported.");

    AST_RESET_ALW: assert property (@(posedge mclk)
        !nrst |=> armSrc_reg == ARM_ALW && window_reg == 16'h0014)
        else $error("Reset values wrong.");

    AST_ALW_ARMS: assert property (@(posedge mclk) disable iff (!nrst)
        state_reg == ST_WAIT_ARM && armSrc_reg == ARM_ALW && !abortCmd |=> state_reg == ST_WAIT_TRIG)
        else $error("Always-armed source did not arm.");

    AST_NO_REARM: assert property (@(posedge mclk) disable iff (!nrst)
        seqScanEnds |=> state_reg == ST_WAIT_TRIG && timerRun == (trigSrc_reg == TRIG_TIMER))
        else $error("Later scan asked for another arm event.");

    AST_ABORT_WAITS: assert property (@(posedge mclk) disable iff (!nrst)
        state_reg == ST_SCAN && abortCmd && !scanDone |=> state_reg == ST_SCAN ##0 abortPending_reg)
        else $error("Abort cut the scan short.");

    AST_ABORT_IDLE: assert property (@(posedge mclk) disable iff (!nrst)
        state_reg == ST_SCAN && abortPending_reg && scanDone |=> isIdle && !timerRun)
        else $error("Abort did not return to idle.");

    AST_SRC_LOCKED: assert property (@(posedge mclk) disable iff (!nrst)
        !isIdle && setArmSource |=> armSrc_reg == $past(armSrc_reg) && cmdRefused)
        else $error("Arm source changed while initiated.");

    AST_ARM_QUERY: assert property (@(posedge mclk) disable iff (!nrst)
        armSourceQuery |=> armQueryValid && armQuerySource == $past(armSrc_reg)
                           && armQueryLine == $past(armLine_reg))
        else $error("Arm source answer wrong.");

    AST_WINDOW_QUERY: assert property (@(posedge mclk) disable iff (!nrst)
        updateSlotCountQuery |=> windowQueryValid && windowQueryData == $past(window_reg))
        else $error("Update window answer wrong.");

    AST_APPLY_UPDATES: assert property (@(posedge mclk) disable iff (!nrst)
        isIdle && initiateCmd && updatesPending |=> applyUpdates && initiated)
        else $error("Pending updates not applied at initiate.");

    AST_WINDOW_RANGE: assert property (@(posedge mclk) disable iff (!nrst)
        window_reg >= 16'h0001 && window_reg <= 16'h0200)
        else $error("Update window out of range.");

    AST_IDLE_IGNORES_ARM: assert property (@(posedge mclk) disable iff (!nrst)
        isIdle && !initiateCmd |=> isIdle && !timerRun)
        else $error("Arm event acted on while idle.");

endmodule

// ---- tac_far_model.sv ----
// Far-side model: arm pins, backplane lines, periodic timer and scan engine.
// Assumes bench requests change just after a rising mclk edge.
`timescale 1ns/100ps
module tac_far_model #(
    parameter int TIMER_PERIOD = 6,
    parameter int SCAN_LEN     = 3
) (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       nrst,
    // Pin request: 0..7 backplane line, 8 terminal, 9 plug-on.
    input  wire logic       pinPulse,
    input  wire logic [3:0] pinSel,
    // Design status.
    input  wire logic       timerRun,
    input  wire logic       scanStart,
    // Pins and scan engine answers.
    output logic            terminalTriggerInput,
    output logic            plugOnTriggerBus,
    output logic [7:0]      ttlTrigLines,
    output logic            timerExpired,
    output logic            scanDone
);
    logic [9:0] pinHold;
    int         pinCnt;
    int         tmrCnt;
    int         scanCnt;

    ////////////////////////////////////////////////////////////////////////
    // Pins idle low and a request holds one pin high for four cycles.
    always_ff @(posedge mclk) begin
        if (!nrst || (pinCnt == 1 && !pinPulse)) begin
            pinHold <= 10'h000;
            pinCnt  <= 0;
        end else if (pinPulse) begin
            pinHold <= 10'h001 << pinSel;
            pinCnt  <= 4;
        end else if (pinCnt != 0) begin
            pinCnt <= pinCnt - 1;
        end
    end
    assign ttlTrigLines         = pinHold[7:0];
    assign terminalTriggerInput = pinHold[8];
    assign plugOnTriggerBus     = pinHold[9];

    // Timer expires periodically only while the design runs it.
    always_ff @(posedge mclk) begin
        timerExpired <= 1'b0;
        if (!nrst || !timerRun) begin
            tmrCnt <= 0;
        end else if (tmrCnt == TIMER_PERIOD - 1) begin
            tmrCnt       <= 0;
            timerExpired <= 1'b1;
        end else begin
            tmrCnt <= tmrCnt + 1;
        end
    end

    // Each started scan finishes a fixed time later.
    always_ff @(posedge mclk) begin
        scanDone <= 1'b0;
        if (!nrst) begin
            scanCnt <= 0;
        end else if (scanStart) begin
            scanCnt <= SCAN_LEN;
        end else if (scanCnt != 0) begin
            scanCnt  <= scanCnt - 1;
            scanDone <= (scanCnt == 1);
        end
    end
endmodule

// ---- tb.sv ----
// Self-checking bench for the trigger arm control block.
// Assumes the far-side model drives pins, timer expiry and scan completion.
`timescale 1ns/100ps
module tb;
    import tac_pkg::*;
    logic          mclk = 1'b0, nrst = 1'b0, pinPulse = 1'b0;
    logic [3:0]    pinSel = 4'h0;
    logic          setArmSource = 1'b0, setTriggerSource = 1'b0, setUpdateWindow = 1'b0;
    tac_arm_src_e  armSourceValue = ARM_ALW;
    tac_trig_src_e triggerSourceValue = TRIG_TIMER;
    logic [2:0]    armLineValue = 3'h0, armQueryLine;
    logic [15:0]   updateWindowValue = 16'h0014, windowQueryData, errCode;
    logic          softwareArmCommand = 1'b0, initiateCmd = 1'b0, abortCmd = 1'b0;
    logic          updatesPending = 1'b0, triggerEvent = 1'b0;
    logic          armSourceQuery = 1'b0, updateSlotCountQuery = 1'b0;
    logic          terminalTriggerInput, plugOnTriggerBus, timerExpired, scanDone;
    logic [7:0]    ttlTrigLines;
    logic          timerRun, scanStart, initiated, applyUpdates, armQueryValid;
    logic          windowQueryValid, errValid, cmdRefused;
    tac_arm_src_e  armQuerySource;
    int            n_mismatch = 0, cmp_count = 0;

    // Design and far side.
    tac_trigger_arm i_tac_trigger_arm (.mclk, .nrst, .terminalTriggerInput, .plugOnTriggerBus, .ttlTrigLines,
        .setArmSource, .armSourceValue, .armLineValue, .setTriggerSource, .triggerSourceValue, .setUpdateWindow,
        .updateWindowValue, .softwareArmCommand, .initiateCmd, .abortCmd, .updatesPending, .timerExpired,
        .triggerEvent, .scanDone, .timerRun, .scanStart, .initiated, .applyUpdates, .armSourceQuery,
        .armQueryValid, .armQuerySource, .armQueryLine, .updateSlotCountQuery, .windowQueryValid,
        .windowQueryData, .errValid, .errCode, .cmdRefused);
    tac_far_model i_tac_far_model (.mclk, .nrst, .pinPulse, .pinSel, .timerRun, .scanStart,
        .terminalTriggerInput, .plugOnTriggerBus, .ttlTrigLines, .timerExpired, .scanDone);

    ////////////////////////////////////////////////////////////////////////
    // Clock at 250 MHz.
    always #2 mclk = ~mclk;

    task automatic cyc(input int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic strobe(ref logic s);
        s = 1'b1;
        cyc();
        s = 1'b0;
    endtask
    task automatic waitFor(ref logic s, input logic v, input int n);
        while (s !== v && n > 0) begin
            cyc();
            n--;
        end
        chk(16'(s), 16'(v));
    endtask
    task automatic setArm(input tac_arm_src_e src, input logic [2:0] ln);
        armSourceValue = src;
        armLineValue   = ln;
        strobe(setArmSource);
    endtask
    task automatic qArm(input tac_arm_src_e src, input logic [2:0] ln);
        strobe(armSourceQuery);
        chk(16'({armQueryValid, armQuerySource, armQueryLine}), 16'({1'b1, src, ln}));
    endtask
    task automatic qWin(input logic [15:0] exp);
        strobe(updateSlotCountQuery);
        chk(16'(windowQueryValid), 16'h1);
        chk(windowQueryData, exp);
    endtask
    task automatic pulsePin(input logic [3:0] i);
        pinSel = i;
        strobe(pinPulse);
        cyc(8);
    endtask
    task automatic stopRun();
        strobe(abortCmd);
        waitFor(initiated, 1'b0, 8);
        chk(16'(timerRun), 16'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_timer();
        updatesPending = 1'b1;
        strobe(initiateCmd);
        chk(16'(applyUpdates), 16'h1);
        updatesPending = 1'b0;
        waitFor(timerRun, 1'b1, 4);
        waitFor(scanStart, 1'b1, 12);
        waitFor(scanDone, 1'b1, 8);
        cyc(2);
        chk(16'(timerRun), 16'h1);
        waitFor(scanStart, 1'b1, 12);
        strobe(abortCmd);
        chk(16'(initiated), 16'h1);
        setArm(ARM_BUS, 3'h0);
        chk(16'(cmdRefused), 16'h1);
        waitFor(initiated, 1'b0, 8);
        qArm(ARM_ALW, 3'h0);
        $display("test timer done");
    endtask
    task automatic t_pin(input tac_arm_src_e src, input logic [2:0] ln, input logic [3:0] good, bad);
        setArm(src, ln);
        qArm(src, ln);
        pulsePin(good);
        strobe(initiateCmd);
        pulsePin(bad);
        chk(16'(timerRun), 16'h0);
        pulsePin(good);
        chk(16'(timerRun), 16'h1);
        stopRun();
    endtask
    task automatic t_soft(input tac_arm_src_e src);
        setArm(src, 3'h0);
        strobe(initiateCmd);
        cyc(6);
        chk(16'(timerRun), 16'h0);
        strobe(softwareArmCommand);
        waitFor(timerRun, 1'b1, 4);
        stopRun();
    endtask
    task automatic t_window();
        logic [15:0] v[4] = '{16'h0000, 16'h0201, 16'h0200, 16'h0001};
        logic [15:0] cur = 16'h0014;
        for (int i = 0; i < 4; i++) begin
            updateWindowValue = v[i];
            strobe(setUpdateWindow);
            chk(16'(cmdRefused), 16'(i < 2));
            if (i >= 2)
                cur = v[i];
            qWin(cur);
        end
        $display("test window done");
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog against a hung handshake.
    initial begin
        #40000;
        n_mismatch++;
        results();
    end

    // Main sequence.
    initial begin
        cyc(4);
        nrst = 1'b1;
        chk(16'({initiated, timerRun}), 16'h0);
        qArm(ARM_ALW, 3'h0);
        qWin(16'h0014);
        t_timer();
        t_pin(ARM_TRM, 3'h0, 4'h8, 4'h9);
        t_pin(ARM_PLG, 3'h0, 4'h9, 4'h8);
        for (int i = 0; i < 8; i++)
            t_pin(ARM_TTL, 3'(i), 4'(i), 4'((i + 1) % 8));
        t_soft(ARM_BUS);
        t_soft(ARM_HOLD);
        triggerSourceValue = TRIG_BUS;
        strobe(setTriggerSource);
        chk(16'(errValid), 16'h1);
        chk(errCode, 16'hff23);
        strobe(initiateCmd);
        chk(16'(errValid), 16'h1);
        strobe(triggerEvent);
        chk(16'(scanStart), 16'h1);
        stopRun();
        triggerSourceValue = TRIG_TIMER;
        strobe(setTriggerSource);
        chk(16'(errValid), 16'h0);
        $display("test sources done");
        t_window();
        results();
    end
endmodule
